// [shared/bdma_pkg.sv]
// Constants and types shared by the banked data memory addressing block
package bdma_pkg;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 16;
  localparam int BANK_W     = 4;
  localparam int OFS_W      = 8;
  localparam int MEM_DEPTH  = 4096;
  localparam int NUM_BANKS  = 16;
  localparam int TWO_WORD_N = 8;
  localparam int A_BIT      = 8;

  localparam logic [3:0]        OPERAND_PREFIX = 4'hF;
  localparam logic [BANK_W-1:0] IMPL_BANK_MAX  = 4'hF;
  localparam logic [BANK_W-1:0] BANK_RESET     = 4'h0;
  localparam logic [OFS_W-1:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [ADDR_W-1:0] SREG_BASE      = 12'hF60;
  localparam logic [ADDR_W-1:0] BANK_SEL_ADDR  = 12'hFE0;
  localparam logic [ADDR_W-1:0] GPR_BASE       = 12'h000;

  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  localparam logic [1:0] SRC_ZERO = 2'h0;
  localparam logic [1:0] SRC_RAM  = 2'h1;
  localparam logic [1:0] SRC_SREG = 2'h2;
  localparam logic [1:0] SRC_BANK = 2'h3;

  localparam logic [WORD_W-1:0] LBL_MASK   = 16'hFF00;
  localparam logic [WORD_W-1:0] LBL_VALUE  = 16'h0100;
  localparam logic [WORD_W-1:0] MOVE_MASK  = 16'hF000;
  localparam logic [WORD_W-1:0] MOVE_VALUE = 16'hC000;

  // First words: call, full_address_move, goto, load_pointer_literal,
  // add_pointer_and_return, call_via_working_reg, stack_relative_move, sub_pointer_and_return
  localparam logic [WORD_W-1:0] TW_MASK [TWO_WORD_N] = '{
    16'hFE00, 16'hF000, 16'hFF00, 16'hFFC0, 16'hFFC0, 16'hFFFF, 16'hFF80, 16'hFFC0};
  localparam logic [WORD_W-1:0] TW_VALUE [TWO_WORD_N] = '{
    16'hEC00, 16'hC000, 16'hEF00, 16'hEE00, 16'hE8C0, 16'h0014, 16'hEB80, 16'hE9C0};

  typedef enum logic [1:0] {SEQ_SINGLE, SEQ_MOVE_OP, SEQ_LIT_OP} bdma_seq_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } bdma_acc_t;
endpackage

// [logic/bdma_ram.sv]
// Data RAM array with registered read data
module bdma_ram (
  input  wire logic                          mclk,  // Core clock
  input  wire logic                          ce,    // Clock enable
  input  wire logic                          re,    // Read strobe
  input  wire logic                          we,    // Write strobe
  input  wire logic [bdma_pkg::ADDR_W-1:0]   addr,  // Byte address
  input  wire logic [bdma_pkg::DATA_W-1:0]   wdata, // Write data
  output logic      [bdma_pkg::DATA_W-1:0]   rdata  // Registered read data
);
  logic [bdma_pkg::DATA_W-1:0] mem [bdma_pkg::MEM_DEPTH];

  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[addr];
    end
  end
endmodule // bdma_ram

// [logic/bdma_core.sv]
// Data address generation, bank register and two-word sequencing
// How it works
// - Eight first-word patterns are recognised as two-word instructions
// - Operand words carry 1111 on top and twelve literal bits below
// - Operand directly after its first word delivers its literal
// - A 1111 word executed alone becomes a no-operation
// - Every data location has a twelve-bit address, 4096 bytes
// - Sixteen banks of 256 bytes, all of them implemented
// - Reads of unimplemented locations return zero
// - Banked address is bank register over the opcode offset
// - Bank register keeps four bits; upper four read zero
// - load_bank_literal writes its immediate into the bank register
// - Unimplemented bank writes dropped, reads zero, status unaffected here
// - full_address_move uses full twelve-bit addresses, ignoring the bank
// - Access map joins bank 0 low part with bank 15 top part
// - Select bit 1 uses the bank register, 0 the access map
// - Access map addressing finishes in one cycle, no bank update
// - Extended set enable changes access map and is an input
// - General RAM starts at address zero and grows upward
// - General RAM is never cleared by any reset
// - Operand read in quarter two, result write in quarter four
module bdma_core (
  input  wire logic                          mclk,          // Core clock
  input  wire logic                          rstn,          // Async reset, active low
  input  wire logic                          ce,            // Clock enable
  input  wire logic [bdma_pkg::WORD_W-1:0]   ir_word,       // Instruction word, taken at Q1
  input  wire logic                          exec_nop,      // Word is skipped or flushed
  input  wire logic                          ext_set_en,    // Extended instruction set enable
  input  wire logic                          op_rd,         // Instruction reads its file operand
  input  wire logic                          op_wr,         // Instruction writes its file operand
  input  wire logic [bdma_pkg::DATA_W-1:0]   wr_data,       // Result byte, taken at Q4
  input  wire logic [bdma_pkg::DATA_W-1:0]   sreg_rdata,    // Special register read data
  output logic      [1:0]                    qphase,        // Current quarter phase
  output logic      [bdma_pkg::DATA_W-1:0]   rd_data,       // Operand byte read
  output logic      [bdma_pkg::DATA_W-1:0]   bank_value,    // data_bank_select readout
  output bdma_pkg::bdma_acc_t                sreg_acc,      // Special register access
  output logic      [bdma_pkg::ADDR_W-1:0]   operand_lit,   // Operand literal
  output logic                               operand_valid, // Literal belongs to this instruction
  output logic                               exec_as_nop,   // Instruction executed as no-operation
  output logic                               ext_map_hit    // Access left to extended mapping
);
  logic [1:0]                    rst_sync_reg;
  logic                          rst_n_int;
  logic [1:0]                    q_reg;
  logic [bdma_pkg::WORD_W-1:0]   ir_reg;
  logic                          ir_nop_reg;
  bdma_pkg::bdma_seq_t           seq_reg;
  bdma_pkg::bdma_seq_t           seq_next;
  logic [bdma_pkg::BANK_W-1:0]   bank_reg;
  logic [bdma_pkg::BANK_W-1:0]   bank_next;
  logic                          bank_load;
  logic [bdma_pkg::DATA_W-1:0]   rd_data_reg;
  logic [bdma_pkg::DATA_W-1:0]   move_data_reg;
  logic                          rd_act_reg;
  logic [1:0]                    rd_src_reg;
  logic [bdma_pkg::DATA_W-1:0]   aux_reg;
  logic [bdma_pkg::ADDR_W-1:0]   lit_reg;
  logic                          lit_valid_reg;
  logic                          nop_reg;
  logic                          ext_hit_reg;
  bdma_pkg::bdma_acc_t           sreg_reg;
  logic [bdma_pkg::DATA_W-1:0]   ram_rdata;

  // Synchroniser runs free so a frozen enable cannot hold reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  wire ph_q1 = (q_reg == bdma_pkg::PH_Q1);
  wire ph_q2 = (q_reg == bdma_pkg::PH_Q2);
  wire ph_q3 = (q_reg == bdma_pkg::PH_Q3);
  wire ph_q4 = (q_reg == bdma_pkg::PH_Q4);

  wire prefix_hit = (ir_reg[15:12] == bdma_pkg::OPERAND_PREFIX);
  wire seq_single = (seq_reg == bdma_pkg::SEQ_SINGLE);
  wire dec_nop = ir_nop_reg | (prefix_hit & seq_single);

  logic [bdma_pkg::TWO_WORD_N-1:0] tw_match;
  genvar gi;
  generate
    for (gi = 0; gi < bdma_pkg::TWO_WORD_N; gi++) begin : g_tw
      assign tw_match[gi] = ((ir_reg & bdma_pkg::TW_MASK[gi]) == bdma_pkg::TW_VALUE[gi]);
    end
  endgenerate
  wire two_word_hit = |tw_match;

  wire is_move   = ((ir_reg & bdma_pkg::MOVE_MASK) == bdma_pkg::MOVE_VALUE);
  wire is_lbl    = ((ir_reg & bdma_pkg::LBL_MASK) == bdma_pkg::LBL_VALUE);
  wire first_ex  = ~dec_nop & ~prefix_hit & two_word_hit;
  wire move_1st  = first_ex & is_move;
  wire move_2nd  = ~dec_nop & prefix_hit & (seq_reg == bdma_pkg::SEQ_MOVE_OP);
  wire lit_2nd   = ~dec_nop & prefix_hit & (seq_reg == bdma_pkg::SEQ_LIT_OP);
  wire lbl_exec  = ~dec_nop & ~prefix_hit & is_lbl;
  wire plain_ex  = ~dec_nop & ~prefix_hit & ~two_word_hit;

  wire [bdma_pkg::OFS_W-1:0] ofs = ir_reg[7:0];
  wire sel_bank = ir_reg[bdma_pkg::A_BIT];
  wire ofs_low  = (ofs < bdma_pkg::ACCESS_SPLIT);

  wire [bdma_pkg::ADDR_W-1:0] map_addr = ofs_low ? {bdma_pkg::ACCESS_LO_BANK, ofs}
                                                 : {bdma_pkg::ACCESS_HI_BANK, ofs};
  wire [bdma_pkg::ADDR_W-1:0] bank_addr = {bank_reg, ofs};
  wire [bdma_pkg::ADDR_W-1:0] short_addr = sel_bank ? bank_addr : map_addr;

  // extended mapping input
  // Low access part (offsets below 60h) is remapped in that mode; left to the extended unit
  wire ext_low = ext_set_en & ~sel_bank & ofs_low;

  wire [bdma_pkg::ADDR_W-1:0] cur_addr = (move_1st | move_2nd) ? ir_reg[11:0] : short_addr;
  wire cur_rd = move_1st | (plain_ex & ~ext_low & op_rd);
  wire cur_wr = move_2nd | (plain_ex & ~ext_low & op_wr);
  wire [bdma_pkg::DATA_W-1:0] cur_wdata = move_2nd ? move_data_reg : wr_data;

  // RAM from zero up to special area
  wire hit_bsel = (cur_addr == bdma_pkg::BANK_SEL_ADDR);
  wire hit_sreg = (cur_addr >= bdma_pkg::SREG_BASE) & ~hit_bsel;
  wire impl     = (cur_addr[11:8] <= bdma_pkg::IMPL_BANK_MAX);
  wire hit_ram  = (cur_addr >= bdma_pkg::GPR_BASE) & ~hit_sreg & ~hit_bsel & impl;

  wire ram_re = ph_q2 & cur_rd & hit_ram;
  wire ram_we = ph_q4 & cur_wr & hit_ram;

  wire [1:0] rd_sel = hit_bsel ? bdma_pkg::SRC_BANK :
                      hit_sreg ? bdma_pkg::SRC_SREG :
                      hit_ram  ? bdma_pkg::SRC_RAM  : bdma_pkg::SRC_ZERO;

  assign bank_load = ph_q4 & (lbl_exec | (cur_wr & hit_bsel));
  assign bank_next = lbl_exec ? ir_reg[3:0] : cur_wdata[3:0];

  assign seq_next = ir_nop_reg ? bdma_pkg::SEQ_SINGLE :
                    move_1st   ? bdma_pkg::SEQ_MOVE_OP :
                    first_ex   ? bdma_pkg::SEQ_LIT_OP : bdma_pkg::SEQ_SINGLE;

  wire [bdma_pkg::DATA_W-1:0] rd_mux = (rd_src_reg == bdma_pkg::SRC_RAM)  ? ram_rdata :
                                       (rd_src_reg == bdma_pkg::SRC_SREG) ? sreg_rdata :
                                       (rd_src_reg == bdma_pkg::SRC_BANK) ? aux_reg : 8'h00;

  wire bdma_pkg::bdma_acc_t sreg_rd_req = '{addr: cur_addr, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
  wire bdma_pkg::bdma_acc_t sreg_wr_req = '{addr: cur_addr, rd: 1'b0, wr: 1'b1, wdata: cur_wdata};

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      q_reg      <= bdma_pkg::PH_Q1;
      ir_reg     <= 16'h0000;
      ir_nop_reg <= 1'b1;
    end else if (ce) begin
      q_reg <= q_reg + 2'h1;
      if (ph_q1) begin
        ir_reg     <= ir_word;
        ir_nop_reg <= exec_nop;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      seq_reg  <= bdma_pkg::SEQ_SINGLE;
      bank_reg <= bdma_pkg::BANK_RESET;
    end else if (ce && ph_q4) begin
      seq_reg <= seq_next;
      if (bank_load) begin
        bank_reg <= bank_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_act_reg <= 1'b0;
      rd_src_reg <= bdma_pkg::SRC_ZERO;
      aux_reg    <= 8'h00;
    end else if (ce && ph_q2) begin
      rd_act_reg <= cur_rd;
      rd_src_reg <= rd_sel;
      aux_reg    <= {4'h0, bank_reg};
    end
  end

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_data_reg   <= 8'h00;
      move_data_reg <= 8'h00;
    end else if (ce) begin
      if (ph_q3 && rd_act_reg) begin
        rd_data_reg <= rd_mux;
      end
      if (ph_q4 && move_1st) begin
        move_data_reg <= rd_data_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      lit_reg       <= 12'h000;
      lit_valid_reg <= 1'b0;
      nop_reg       <= 1'b0;
      ext_hit_reg   <= 1'b0;
    end else if (ce && ph_q2) begin
      lit_reg       <= ir_reg[11:0];
      lit_valid_reg <= lit_2nd | move_2nd;
      nop_reg       <= dec_nop;
      ext_hit_reg   <= plain_ex & ext_low & (op_rd | op_wr);
    end
  end

  // Special registers see one-clock strobes after Q2 and Q4
  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      sreg_reg <= '0;
    end else if (ce) begin
      if (ph_q2 && cur_rd && hit_sreg) begin
        sreg_reg <= sreg_rd_req;
      end else if (ph_q4 && cur_wr && hit_sreg) begin
        sreg_reg <= sreg_wr_req;
      end else begin
        sreg_reg <= '0;
      end
    end
  end

  bdma_ram u_ram (
    .mclk  (mclk),
    .ce    (ce),
    .re    (ram_re),
    .we    (ram_we),
    .addr  (cur_addr),
    .wdata (cur_wdata),
    .rdata (ram_rdata)
  );

  assign qphase        = q_reg;
  assign rd_data       = rd_data_reg;
  assign bank_value    = {4'h0, bank_reg};
  assign sreg_acc      = sreg_reg;
  assign operand_lit   = lit_reg;
  assign operand_valid = lit_valid_reg;
  assign exec_as_nop   = nop_reg;
  assign ext_map_hit   = ext_hit_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_int);

  a_bank_upper_zero: assert property (bank_value[7:4] == 4'h0)
    else $error("bank register upper bits not zero");
  a_lbl_loads_bank: assert property (ce && ph_q4 && lbl_exec |=> bank_value == {4'h0, $past(ir_reg[3:0])})
    else $error("bank literal load failed");
  a_orphan_is_nop: assert property (ce && ph_q2 && prefix_hit && seq_single |=> nop_reg && !lit_valid_reg)
    else $error("orphan operand word not executed as nop");
  a_operand_lit_used: assert property (ce && ph_q2 && (lit_2nd || move_2nd) |=>
                                       lit_valid_reg && lit_reg == $past(ir_reg[11:0]))
    else $error("operand literal not delivered");
  a_banked_address: assert property (sel_bank && !(move_1st || move_2nd) |-> cur_addr == {bank_reg, ofs})
    else $error("banked address wrong");
  a_access_map_addr: assert property (!sel_bank && !(move_1st || move_2nd) |-> cur_addr[11:8] == (ofs_low ? 4'h0 : 4'hF))
    else $error("access map address wrong");
  a_move_no_bank: assert property ((move_1st || move_2nd) |-> cur_addr == ir_reg[11:0])
    else $error("full address move used bank register");
  a_ram_phases: assert property ((ram_re |-> ph_q2) and (ram_we |-> ph_q4))
    else $error("ram access outside its quarter phase");
  a_flush_clears_seq: assert property (ce && ph_q4 && ir_nop_reg |=> seq_reg == bdma_pkg::SEQ_SINGLE)
    else $error("flushed word left operand flag set");
  a_two_word_arms: assert property (ce && ph_q4 && first_ex |=> seq_reg != bdma_pkg::SEQ_SINGLE)
    else $error("two-word first word did not arm operand");
  a_unmapped_zero: assert property (ce && ph_q3 && rd_act_reg && rd_src_reg == bdma_pkg::SRC_ZERO |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_map_one_cycle: assert property ((ce && ph_q2 && ram_re && !sel_bank) ##1 (ce && ph_q3) |=>
                                    rd_data == $past(ram_rdata))
    else $error("access map read stalled");
endmodule // bdma_core

// [test/bdma_sreg_model.sv]
// Special register file model answering the block's special register accesses
module bdma_sreg_model (
  input  wire logic                        mclk,      // Core clock
  input  wire bdma_pkg::bdma_acc_t         sreg_acc,  // Access from the block
  output logic [bdma_pkg::DATA_W-1:0]      sreg_rdata // Read data back
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [12'hF60:12'hFFF];
  logic [7:0] last_rd;
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    last_rd = 8'h00;
  end
  // Not selected: inverse of last read, so a stale value never matches
  always_comb sreg_rdata = sreg_acc.rd ? regs[sreg_acc.addr] : ~last_rd;
  always @(posedge mclk) begin
    if (sreg_acc.rd) last_rd <= regs[sreg_acc.addr];
    if (sreg_acc.wr) regs[sreg_acc.addr] <= sreg_acc.wdata;
  end
endmodule // bdma_sreg_model

// [test/tb_banked_data_memory_addressing.sv]
// Self-checking bench for the data address generation block
module tb_banked_data_memory_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk = 1'b0;
  logic                rstn = 1'b0;
  logic                ce = 1'b1;
  logic [15:0]         ir_word = 16'h0000;
  logic                exec_nop = 1'b0;
  logic                ext_set_en = 1'b0;
  logic                op_rd = 1'b0;
  logic                op_wr = 1'b0;
  logic [7:0]          wr_data = 8'h00;
  logic [7:0]          sreg_rdata;
  logic [1:0]          qphase;
  logic [7:0]          rd_data;
  logic [7:0]          bank_value;
  bdma_pkg::bdma_acc_t sreg_acc;
  logic [11:0]         operand_lit;
  logic                operand_valid;
  logic                exec_as_nop;
  logic                ext_map_hit;
  int                  err_count = 0;
  int                  comparisons = 0;
  int                  cycles = 0;

  bdma_core DUT (.mclk, .rstn, .ce, .ir_word, .exec_nop, .ext_set_en, .op_rd, .op_wr, .wr_data,
                 .sreg_rdata, .qphase, .rd_data, .bank_value, .sreg_acc, .operand_lit,
                 .operand_valid, .exec_as_nop, .ext_map_hit);
  bdma_sreg_model sreg_far (.mclk, .sreg_acc, .sreg_rdata);

  always #20 mclk = ~mclk;

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Far above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic apply_reset();
    @(posedge mclk) rstn <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
  endtask

  // Drive at the edge entering Q1, return once rd_data and flags have landed
  task automatic issue(input logic [15:0] w, input logic nop, input logic rd, input logic wr,
                       input logic [7:0] d);
    while (qphase !== 2'h3) @(negedge mclk);
    @(posedge mclk);
    ir_word <= w;
    exec_nop <= nop;
    op_rd <= rd;
    op_wr <= wr;
    wr_data <= d;
    @(negedge mclk);
    while (qphase !== 2'h3) @(negedge mclk);
  endtask

  task automatic acc(input logic a, input logic [7:0] ofs, input logic wr, input logic [7:0] d);
    issue({7'h10, a, ofs}, 1'b0, ~wr, wr, d);
  endtask

  task automatic load_bank(input logic [3:0] b);
    issue({12'h010, b}, 1'b0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_banked();
    load_bank(4'h5);
    acc(1'b1, 8'h34, 1'b1, 8'hA5);
    acc(1'b1, 8'h34, 1'b0, 8'h00);
    chk_val("rd_data", 12'h0A5, rd_data);
    chk_val("bank_value", 12'h005, bank_value);
  endtask

  task automatic t_access_map();
    load_bank(4'h0);
    acc(1'b1, 8'h12, 1'b1, 8'h3C);
    acc(1'b1, 8'h00, 1'b1, 8'h11);
    load_bank(4'h5);
    acc(1'b0, 8'h12, 1'b0, 8'h00);
    chk_val("rd_data", 12'h03C, rd_data);
    acc(1'b0, 8'h00, 1'b0, 8'h00);
    chk_val("rd_data", 12'h011, rd_data);
    acc(1'b0, 8'h80, 1'b1, 8'h42);
    acc(1'b0, 8'h80, 1'b0, 8'h00);
    chk_val("rd_data", 12'h042, rd_data);
    acc(1'b0, 8'h90, 1'b0, 8'h00);
    chk_val("rd_data", 12'h000, rd_data);
    acc(1'b0, 8'hE0, 1'b0, 8'h00);
    chk_val("rd_data", 12'h005, rd_data);
    acc(1'b0, 8'hE0, 1'b1, 8'hFF);
    acc(1'b0, 8'hE0, 1'b0, 8'h00);
    chk_val("rd_data", 12'h00F, rd_data);
    chk_val("bank_value", 12'h00F, bank_value);
    acc(1'b1, 8'h80, 1'b0, 8'h00);
    chk_val("rd_data", 12'h042, rd_data);
  endtask

  task automatic t_move();
    load_bank(4'h7);
    issue(16'hC534, 1'b0, 1'b0, 1'b0, 8'h00);
    issue(16'hF2AB, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_flag("operand_valid", 1'b1, operand_valid);
    chk_val("operand_lit", 12'h2AB, operand_lit);
    load_bank(4'h2);
    acc(1'b1, 8'hAB, 1'b0, 8'h00);
    chk_val("rd_data", 12'h0A5, rd_data);
  endtask

  task automatic t_orphan();
    issue(16'hF456, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_flag("exec_as_nop", 1'b1, exec_as_nop);
    chk_flag("operand_valid", 1'b0, operand_valid);
    issue(16'hC123, 1'b1, 1'b0, 1'b0, 8'h00);
    issue(16'hF456, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_flag("exec_as_nop", 1'b1, exec_as_nop);
  endtask

  // Operands land at 300h upward, away from every value checked later
  task automatic t_all_two_word();
    for (int i = 0; i < bdma_pkg::TWO_WORD_N; i++) begin
      issue(bdma_pkg::TW_VALUE[i], 1'b0, 1'b0, 1'b0, 8'h00);
      issue(16'hF300 | 16'(i), 1'b0, 1'b0, 1'b0, 8'h00);
      chk_flag("operand_valid", 1'b1, operand_valid);
      chk_val("operand_lit", 12'h300 | 12'(i), operand_lit);
    end
  endtask

  task automatic t_ext();
    @(posedge mclk) ext_set_en <= 1'b1;
    @(negedge mclk);
    acc(1'b0, 8'h10, 1'b0, 8'h00);
    chk_flag("ext_map_hit", 1'b1, ext_map_hit);
    acc(1'b0, 8'h80, 1'b0, 8'h00);
    chk_flag("ext_map_hit", 1'b0, ext_map_hit);
    chk_val("rd_data", 12'h042, rd_data);
    @(posedge mclk) ext_set_en <= 1'b0;
    @(negedge mclk);
    acc(1'b0, 8'h10, 1'b0, 8'h00);
    chk_flag("ext_map_hit", 1'b0, ext_map_hit);
  endtask

  task automatic t_keep_ram();
    apply_reset();
    chk_val("bank_value", 12'h000, bank_value);
    chk_flag("operand_valid", 1'b0, operand_valid);
    load_bank(4'h2);
    acc(1'b1, 8'hAB, 1'b0, 8'h00);
    chk_val("rd_data", 12'h0A5, rd_data);
  endtask

  initial begin
    apply_reset();
    chk_val("bank_value", 12'h000, bank_value);
    t_banked();
    t_access_map();
    t_move();
    t_orphan();
    t_all_two_word();
    t_ext();
    t_keep_ram();
    test_done();
  end
endmodule // tb_banked_data_memory_addressing
